// [include/rfdl_pkg.sv]
// constants and state type for the contactless page-write and lock command handler
package rfdl_pkg;
  // command opcodes
  localparam logic [7:0] OP_PAGE_WRITE = 8'h54; // page_write_cmd
  localparam logic [7:0] OP_RD_RLOCK = 8'h6A; // read_page_readlock_array_cmd
  localparam logic [7:0] OP_RD_WLOCK = 8'h6C; // read_page_writelock_array_cmd
  localparam logic [7:0] OP_SET_RLOCK = 8'h7F; // set_page_readlock_array_cmd
  localparam logic [7:0] OP_SET_WLOCK = 8'h7E; // set_page_writelock_array_cmd
  localparam logic [7:0] OP_PWD = 8'h40; // lock_password_verify_cmd
  // 4-bit answers
  localparam logic [3:0] ACK_CODE = 4'hA;
  localparam logic [3:0] NAK_CODE = 4'h0;
  // frame lengths without the two crc bytes
  localparam logic [6:0] LEN_PAGE_WRITE = 7'h42; // opcode, page, 64 data
  localparam logic [6:0] LEN_LOCK_READ = 7'h01; // opcode only
  localparam logic [6:0] LEN_LOCK_WRITE = 7'h21; // opcode, 32 data
  localparam logic [6:0] LEN_PWD = 7'h05; // opcode, 4 password
  localparam logic [6:0] CNT_MAX = 7'h7F; // byte counter saturation
  // sizes
  localparam logic [6:0] PAGE_BYTES = 7'h40; // 64 bytes per page
  localparam logic [7:0] NUM_PAGES = 8'h40; // 64 pages of data memory
  localparam logic [5:0] LOCK_LAST = 6'h1F; // 32-byte lock region, last index
  localparam int LOCK_BYTES = 8; // lock bytes ahead of reserved_bytes
  localparam int ARR_BYTES = 32; // lock bytes plus reserved_bytes
  // timing
  localparam int RSP_MIN_N = 9; // least response latency n
  localparam logic [3:0] RSP_MIN_CYC = 4'(RSP_MIN_N); // in core cycles
  localparam int CORE_CLK_KHZ = 50000; // core_clk rate
  localparam int TIMEOUT_MS = 5; // reader gives up after this
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CORE_CLK_KHZ; // rounded down
  // command engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_MEMWR = 5'h04,
    ST_WAIT = 5'h08,
    ST_SEND = 5'h10
  } rfdl_state_t;
endpackage : rfdl_pkg

// [hw/rfdl_page_lock_cmd.sv]
// contactless page write, lock array read/write and lock password command handler
`timescale 1ns/1ps
module rfdl_page_lock_cmd #(
  parameter int unsigned TIMEOUT_CYC = rfdl_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic lk_rx_valid,
  input wire logic [7:0] lk_rx_byte,
  input wire logic lk_rx_end,
  input wire logic lk_rx_crc_ok,
  output logic lk_tx_valid,
  output logic [7:0] lk_tx_data,
  output logic lk_tx_nibble,
  input wire logic rf_idle,
  input wire logic ser_cmd,
  output logic ser_hold,
  input wire logic [31:0] lock_password,
  output logic mem_we,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_busy,
  output logic [63:0] page_readlock_array,
  output logic [63:0] page_writelock_array,
  output logic datamem_unlocked_state
);
  // link side: receive event channel and transmit handshake
  logic ev_tog_reg, ev_tog_next; // flips once per received byte or frame end
  logic [9:0] ev_data_reg, ev_data_next; // {end, crc ok, byte}
  logic req_s1_reg, req_s2_reg; // transmit request synchroniser
  logic ack_tog_reg, ack_tog_next; // returned to core once a word is sent
  logic lk_tx_valid_next, lk_tx_nibble_next; // next word strobe and kind
  logic [7:0] lk_tx_data_next;
  // core side state
  rfdl_pkg::rfdl_state_t state_reg, state_next;
  logic ev_s1_reg, ev_s2_reg, ev_s3_reg; // event toggle synchroniser
  logic ack_s1_reg, ack_s2_reg; // ack toggle synchroniser
  logic ser_s1_reg, ser_s2_reg; // serial command pin synchroniser
  logic [6:0] cnt_reg, cnt_next; // bytes received in frame
  logic [7:0] op_reg, op_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] buf_reg [64];
  logic [7:0] buf_next [64];
  logic [7:0] rlock_reg [32];
  logic [7:0] rlock_next [32];
  logic [7:0] wlock_reg [32];
  logic [7:0] wlock_next [32];
  logic auth_reg, auth_next; // datamem_unlocked_state
  logic [3:0] code_reg, code_next; // pending 4-bit answer
  logic data_rsp_reg, data_rsp_next; // answer is 32 data bytes
  logic [3:0] lat_reg, lat_next; // cycles since frame end, saturating
  logic [31:0] tmo_reg, tmo_next; // write cycle watchdog
  logic [6:0] idx_reg, idx_next; // write or send index
  logic tx_req_reg, tx_req_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic tx_nib_reg, tx_nib_next;
  logic mem_we_next;
  logic [11:0] mem_addr_next;
  logic [7:0] mem_wdata_next;
  logic ev, ev_end, ev_crc; // ev: one core cycle per link event
  logic [7:0] ev_byte;
  logic [6:0] bi; // buffer slot of current byte

  // link event capture, one toggle per byte or frame end
  always_comb begin
    ev_tog_next = ev_tog_reg;
    ev_data_next = ev_data_reg;
    if (lk_rx_valid || lk_rx_end) begin
      ev_tog_next = ~ev_tog_reg;
      ev_data_next = {lk_rx_end, lk_rx_crc_ok, lk_rx_byte};
    end
  end

  // link transmit: present each word once the core request toggles
  always_comb begin
    ack_tog_next = ack_tog_reg;
    lk_tx_valid_next = 1'b0;
    lk_tx_data_next = lk_tx_data;
    lk_tx_nibble_next = lk_tx_nibble;
    if (req_s2_reg != ack_tog_reg) begin
      ack_tog_next = req_s2_reg;
      lk_tx_valid_next = 1'b1;
      lk_tx_data_next = tx_byte_reg; // stable until ack returns
      lk_tx_nibble_next = tx_nib_reg;
    end
  end

  // link domain registers
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      {ev_tog_reg, ev_data_reg, ack_tog_reg} <= 12'h0; // no event, no word sent
      {req_s2_reg, req_s1_reg} <= 2'h0;
      {lk_tx_valid, lk_tx_data, lk_tx_nibble} <= 10'h0;
    end else begin
      {ev_tog_reg, ev_data_reg, ack_tog_reg} <= {ev_tog_next, ev_data_next, ack_tog_next};
      {req_s2_reg, req_s1_reg} <= {req_s1_reg, tx_req_reg}; // request synchroniser
      {lk_tx_valid, lk_tx_data, lk_tx_nibble} <= {lk_tx_valid_next, lk_tx_data_next, lk_tx_nibble_next};
    end
  end

  // event decode; link data is stable while its toggle is synchronised
  assign ev = ev_s2_reg ^ ev_s3_reg;
  assign {ev_end, ev_crc, ev_byte} = ev_data_reg;
  assign bi = cnt_reg - ((op_reg == rfdl_pkg::OP_PAGE_WRITE) ? 7'h02 : 7'h01);

  // command engine next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    page_next = page_reg;
    buf_next = buf_reg;
    rlock_next = rlock_reg;
    wlock_next = wlock_reg;
    auth_next = auth_reg;
    code_next = code_reg;
    data_rsp_next = data_rsp_reg;
    lat_next = lat_reg;
    tmo_next = tmo_reg;
    idx_next = idx_reg;
    tx_req_next = tx_req_reg;
    tx_byte_next = tx_byte_reg;
    tx_nib_next = tx_nib_reg;
    mem_we_next = 1'b0;
    mem_addr_next = mem_addr;
    mem_wdata_next = mem_wdata;
    if (rf_idle) begin
      auth_next = 1'b0; // a later session must verify again
    end
    case (state_reg)
      rfdl_pkg::ST_IDLE: begin
        // new frame only while no serial command owns the memory
        if (ev && !ev_end && !ser_s2_reg) begin
          op_next = ev_byte;
          cnt_next = 7'h01;
          state_next = rfdl_pkg::ST_RECV;
        end
      end
      rfdl_pkg::ST_RECV: begin
        if (ser_s2_reg) begin
          state_next = rfdl_pkg::ST_IDLE; // serial wins before any write
        end else if (ev && !ev_end) begin
          if (cnt_reg != rfdl_pkg::CNT_MAX) begin
            cnt_next = cnt_reg + 7'h01;
          end
          if (op_reg == rfdl_pkg::OP_PAGE_WRITE && cnt_reg == 7'h01) begin
            page_next = ev_byte;
          end
          if (bi < rfdl_pkg::PAGE_BYTES) begin
            buf_next[bi[5:0]] = ev_byte;
          end
        end else if (ev) begin
          // frame end: decide; a bad crc answers NAK and leaves the locks and the unlocked state as they were
          lat_next = 4'h0;
          code_next = rfdl_pkg::NAK_CODE; // default rejection
          data_rsp_next = 1'b0;
          state_next = rfdl_pkg::ST_WAIT;
          case (op_reg)
            rfdl_pkg::OP_PAGE_WRITE: begin
              // locked or out-of-range page answers NAK
              if (ev_crc && cnt_reg == rfdl_pkg::LEN_PAGE_WRITE && page_reg < rfdl_pkg::NUM_PAGES
                  && !page_writelock_array[page_reg[5:0]]) begin
                state_next = rfdl_pkg::ST_MEMWR;
                idx_next = 7'h00;
                tmo_next = 32'h0000_0000;
              end
            end
            rfdl_pkg::OP_RD_RLOCK, rfdl_pkg::OP_RD_WLOCK: begin
              if (ev_crc && cnt_reg == rfdl_pkg::LEN_LOCK_READ) begin
                data_rsp_next = 1'b1;
              end
            end
            rfdl_pkg::OP_SET_RLOCK, rfdl_pkg::OP_SET_WLOCK: begin
              // only in the unlocked state
              if (ev_crc && cnt_reg == rfdl_pkg::LEN_LOCK_WRITE && auth_reg) begin
                code_next = rfdl_pkg::ACK_CODE;
                for (int i = 0; i < rfdl_pkg::ARR_BYTES; i++) begin
                  // bytes 0..7 lock, 8..31 reserved; bits only ever set
                  if (op_reg == rfdl_pkg::OP_SET_RLOCK) begin
                    rlock_next[i] = rlock_reg[i] | buf_reg[i];
                  end else begin
                    wlock_next[i] = wlock_reg[i] | buf_reg[i];
                  end
                end
              end
            end
            rfdl_pkg::OP_PWD: begin
              // first password byte is the most significant
              if (ev_crc && cnt_reg == rfdl_pkg::LEN_PWD
                  && {buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3]} == lock_password) begin
                auth_next = 1'b1; // set wins over rf_idle
                code_next = rfdl_pkg::ACK_CODE;
              end
            end
            default: begin
              code_next = rfdl_pkg::NAK_CODE; // unknown opcode
            end
          endcase
        end
      end
      rfdl_pkg::ST_MEMWR: begin
        // stream the page into memory, then wait for the write cycle
        tmo_next = tmo_reg + 32'h0000_0001;
        if (lat_reg != 4'hF) begin
          lat_next = lat_reg + 4'h1;
        end
        if (idx_reg < rfdl_pkg::PAGE_BYTES) begin
          mem_we_next = 1'b1;
          mem_addr_next = {page_reg[5:0], idx_reg[5:0]};
          mem_wdata_next = buf_reg[idx_reg[5:0]];
          idx_next = idx_reg + 7'h01;
        end else if (!mem_busy && !mem_we) begin
          code_next = rfdl_pkg::ACK_CODE;
          state_next = rfdl_pkg::ST_WAIT;
        end
        if (tmo_reg == TIMEOUT_CYC - 1) begin
          state_next = rfdl_pkg::ST_IDLE; // past the reader timeout, stay silent
        end
      end
      rfdl_pkg::ST_WAIT: begin
        if (ser_s2_reg && data_rsp_reg) begin
          state_next = rfdl_pkg::ST_IDLE; // read answer abandoned for serial
        end else if (lat_reg >= rfdl_pkg::RSP_MIN_CYC) begin
          // launch first word no earlier than the least latency
          tx_req_next = ~tx_req_reg;
          idx_next = 7'h00;
          tx_nib_next = ~data_rsp_reg;
          tx_byte_next = data_rsp_reg ? ((op_reg == rfdl_pkg::OP_RD_RLOCK) ? rlock_reg[0] : wlock_reg[0])
                                      : {4'h0, code_reg};
          state_next = rfdl_pkg::ST_SEND;
        end else begin
          lat_next = lat_reg + 4'h1;
        end
      end
      rfdl_pkg::ST_SEND: begin
        // next data byte after the link has taken the previous one
        if (ack_s2_reg == tx_req_reg) begin
          if (data_rsp_reg && idx_reg[5:0] != rfdl_pkg::LOCK_LAST) begin
            idx_next = idx_reg + 7'h01;
            tx_req_next = ~tx_req_reg;
            tx_byte_next = (op_reg == rfdl_pkg::OP_RD_RLOCK) ? rlock_reg[idx_next[4:0]] : wlock_reg[idx_next[4:0]];
          end else begin
            state_next = rfdl_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_next = rfdl_pkg::ST_IDLE;
      end
    endcase
  end

  // core domain registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= rfdl_pkg::ST_IDLE;
      {ev_s1_reg, ev_s2_reg, ev_s3_reg, ack_s1_reg, ack_s2_reg, ser_s1_reg, ser_s2_reg} <= 7'h00;
      {cnt_reg, op_reg, page_reg} <= 23'h0; // no frame in progress
      for (int i = 0; i < 64; i++) buf_reg[i] <= 8'h00;
      for (int i = 0; i < rfdl_pkg::ARR_BYTES; i++) rlock_reg[i] <= 8'h00;
      for (int i = 0; i < rfdl_pkg::ARR_BYTES; i++) wlock_reg[i] <= 8'h00;
      {auth_reg, data_rsp_reg, lat_reg, idx_reg} <= 13'h0; // locked, nothing pending
      code_reg <= rfdl_pkg::NAK_CODE;
      tmo_reg <= 32'h0000_0000;
      {tx_req_reg, tx_byte_reg, tx_nib_reg} <= 10'h0;
      {mem_we, mem_addr, mem_wdata} <= 21'h0;
    end else begin
      state_reg <= state_next;
      {ev_s3_reg, ev_s2_reg, ev_s1_reg} <= {ev_s2_reg, ev_s1_reg, ev_tog_reg}; // event toggle, third for edge
      {ack_s2_reg, ack_s1_reg} <= {ack_s1_reg, ack_tog_reg}; // link ack toggle
      {ser_s2_reg, ser_s1_reg} <= {ser_s1_reg, ser_cmd}; // serial pin
      {cnt_reg, op_reg, page_reg} <= {cnt_next, op_next, page_next};
      buf_reg <= buf_next;
      rlock_reg <= rlock_next;
      wlock_reg <= wlock_next;
      {auth_reg, data_rsp_reg, lat_reg, idx_reg} <= {auth_next, data_rsp_next, lat_next, idx_next};
      {code_reg, tmo_reg} <= {code_next, tmo_next};
      {tx_req_reg, tx_byte_reg, tx_nib_reg} <= {tx_req_next, tx_byte_next, tx_nib_next};
      {mem_we, mem_addr, mem_wdata} <= {mem_we_next, mem_addr_next, mem_wdata_next};
    end
  end

  // flat lock vectors, page p is bit p
  for (genvar g = 0; g < rfdl_pkg::LOCK_BYTES; g++) begin : g_lock
    assign page_readlock_array[8*g+:8] = rlock_reg[g];
    assign page_writelock_array[8*g+:8] = wlock_reg[g];
  end
  assign datamem_unlocked_state = auth_reg;
  assign ser_hold = (state_reg == rfdl_pkg::ST_MEMWR); // write cycle owns memory

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic fe_core;
  assign fe_core = (state_reg == rfdl_pkg::ST_RECV) && ev && ev_end && !ser_s2_reg;
  locked_page_nak_a: assert property (fe_core && op_reg == rfdl_pkg::OP_PAGE_WRITE
      && page_writelock_array[page_reg[5:0]] |=> state_reg == rfdl_pkg::ST_WAIT && code_reg == rfdl_pkg::NAK_CODE)
    else $error("locked page not refused");
  page_stream_a: assert property ($fell(mem_we) |-> $past(mem_addr[5:0]) == 6'h3F)
    else $error("page write not 64 bytes");
  write_hold_a: assert property (mem_we |-> ser_hold) else $error("serial not held during write");
  min_latency_a: assert property ($changed(tx_req_reg) && $past(state_reg) == rfdl_pkg::ST_WAIT
      |-> $past(lat_reg) >= rfdl_pkg::RSP_MIN_CYC) else $error("answer too early");
  lock_or_a: assert property ((($past(page_writelock_array) & ~page_writelock_array) == 64'h0)
      && (($past(page_readlock_array) & ~page_readlock_array) == 64'h0)) else $error("lock bit cleared");
  lock_auth_a: assert property ($changed(page_writelock_array) || $changed(page_readlock_array) |-> $past(auth_reg))
    else $error("lock changed while locked");
  crc_nak_a: assert property (fe_core && !ev_crc |=> code_reg == rfdl_pkg::NAK_CODE && !data_rsp_reg
      && $stable(auth_reg) && state_reg == rfdl_pkg::ST_WAIT) else $error("crc failure not refused");
  serial_abort_a: assert property (state_reg == rfdl_pkg::ST_RECV && ser_s2_reg |=> state_reg == rfdl_pkg::ST_IDLE)
    else $error("rf not aborted");
  idle_clear_a: assert property (rf_idle && !fe_core |=> !auth_reg) else $error("unlock survived idle");
  write_ack_a: assert property (state_reg == rfdl_pkg::ST_MEMWR && state_next == rfdl_pkg::ST_WAIT
      |=> code_reg == rfdl_pkg::ACK_CODE) else $error("page write not acked");
  cov_page_write: cover property ($fell(mem_we) ##[1:200] $changed(tx_req_reg));
  cov_unlock: cover property ($rose(auth_reg));
  cov_lock_read: cover property (data_rsp_reg && state_reg == rfdl_pkg::ST_SEND ##[1:1000] state_reg == rfdl_pkg::ST_IDLE);
endmodule : rfdl_page_lock_cmd

// [test/rfdl_reader_model.sv]
// behavioural reader model driving command frames into the link receive side
`timescale 1ns/1ps
module rfdl_reader_model (
  input wire logic link_clk,
  output logic lk_rx_valid,
  output logic [7:0] lk_rx_byte,
  output logic lk_rx_end,
  output logic lk_rx_crc_ok
);
  // idle lines at time zero
  initial begin
    lk_rx_valid = 1'b0;
    lk_rx_byte = 8'h5A;
    lk_rx_end = 1'b0;
    lk_rx_crc_ok = 1'b0;
  end

  // one frame: bytes four link cycles apart, then the end pulse with crc status
  task automatic send_frame(input logic [7:0] fr[$], input logic good);
    int i;
    for (i = 0; i < fr.size(); i++) begin
      @(posedge link_clk);
      #1;
      lk_rx_valid = 1'b1; // opcode first, then fields
      lk_rx_byte = fr[i];
      @(posedge link_clk);
      #1;
      lk_rx_valid = 1'b0;
      lk_rx_byte = ~fr[i]; // released line shows no stale byte
      repeat (2) @(posedge link_clk);
    end
    @(posedge link_clk);
    #1;
    lk_rx_end = 1'b1;
    lk_rx_crc_ok = good;
    @(posedge link_clk);
    #1;
    lk_rx_end = 1'b0;
    lk_rx_crc_ok = ~good; // crc status only meaningful with the end pulse
  endtask : send_frame
endmodule : rfdl_reader_model

// [test/tb_top.sv]
// self-checking bench for the contactless page write and lock command handler
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic link_clk;
  logic rst_n;
  logic link_rst_n;
  logic rf_idle;
  logic ser_cmd;
  logic mem_busy;
  logic [31:0] lock_password;
  logic lk_rx_valid;
  logic [7:0] lk_rx_byte;
  logic lk_rx_end;
  logic lk_rx_crc_ok;
  logic lk_tx_valid;
  logic [7:0] lk_tx_data;
  logic lk_tx_nibble;
  logic ser_hold;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [63:0] page_readlock_array;
  logic [63:0] page_writelock_array;
  logic datamem_unlocked_state;
  int failures = 0;
  int n_tests = 0;
  int seed;
  int lat_cnt = 0;
  int busy_cnt = 0;
  logic first_word = 1'b0;
  logic [9:0] ans_q[$]; // {care, nibble, data}
  logic [19:0] mem_q[$]; // {addr, data}
  logic [7:0] fr[$];
  logic [63:0] wl_exp;
  logic [63:0] rl_exp;
  logic [63:0] tmp;
  logic [7:0] rsv[2][24] = '{default: 8'h00}; // expected reserved bytes, index 1 = write-lock side
  logic [7:0] rsv_f[24]; // reserved bytes of the frame being built

  // clocks, link clock offset in phase
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  rfdl_page_lock_cmd #(.TIMEOUT_CYC(200)) DUT (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_rst_n(link_rst_n), .lk_rx_valid(lk_rx_valid), .lk_rx_byte(lk_rx_byte), .lk_rx_end(lk_rx_end),
    .lk_rx_crc_ok(lk_rx_crc_ok), .lk_tx_valid(lk_tx_valid), .lk_tx_data(lk_tx_data), .lk_tx_nibble(lk_tx_nibble),
    .rf_idle(rf_idle), .ser_cmd(ser_cmd), .ser_hold(ser_hold), .lock_password(lock_password), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_busy(mem_busy), .page_readlock_array(page_readlock_array),
    .page_writelock_array(page_writelock_array), .datamem_unlocked_state(datamem_unlocked_state));

  rfdl_reader_model rdr (.link_clk(link_clk), .lk_rx_valid(lk_rx_valid), .lk_rx_byte(lk_rx_byte),
    .lk_rx_end(lk_rx_end), .lk_rx_crc_ok(lk_rx_crc_ok));

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task close_out;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // memory side: checks each write, then stays busy a few cycles
  always @(posedge core_clk) begin : mem_mon
    logic [19:0] m;
    if (mem_we) begin
      m = (mem_q.size() > 0) ? mem_q.pop_front() : 20'hFFFFF;
      check(64'({mem_addr, mem_wdata}), 64'(m));
      check(64'(ser_hold), 64'h1);
    end
    busy_cnt <= mem_we ? 6 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    mem_busy <= mem_we || busy_cnt > 1;
  end

  // core cycles since the last frame end
  always @(posedge core_clk) lat_cnt++;

  // answer monitor: oldest note against each word, latency on the first
  always @(posedge link_clk) begin : ans_mon
    logic [9:0] a;
    if (lk_rx_end) begin
      lat_cnt = 0;
      first_word = 1'b1;
    end
    if (lk_tx_valid) begin
      a = (ans_q.size() > 0) ? ans_q.pop_front() : 10'h3FF;
      if (first_word) check(64'(lat_cnt >= rfdl_pkg::RSP_MIN_N), 64'h1);
      first_word = 1'b0;
      if (a[9]) check(64'({lk_tx_nibble, lk_tx_data}), 64'(a[8:0]));
    end
  end

  // note an expected nibble answer
  task automatic expect_nib(input logic [3:0] n);
    ans_q.push_back({2'b11, 4'h0, n});
  endtask : expect_nib

  // bounded wait for all noted answers
  task automatic wait_answers;
    int k;
    for (k = 0; k < 4000 && ans_q.size() > 0; k++) @(posedge core_clk);
    check(64'(ans_q.size()), 64'h0);
    repeat (20) @(posedge core_clk);
    #1;
  endtask : wait_answers

  // lock write frame: 8 lock bytes then 24 reserved bytes
  task automatic lock_frame(input logic [7:0] op, input logic [63:0] lk);
    int i;
    fr = {op};
    for (i = 0; i < 24; i++) rsv_f[i] = 8'($random(seed));
    for (i = 0; i < rfdl_pkg::ARR_BYTES; i++) fr.push_back(i < 8 ? lk[8*i+:8] : rsv_f[i-8]);
  endtask : lock_frame

  task automatic lock_write(input logic [7:0] op, input logic [63:0] lk, input logic [3:0] n);
    lock_frame(op, lk);
    expect_nib(n);
    rdr.send_frame(fr, 1'b1);
    wait_answers();
    if (n == rfdl_pkg::ACK_CODE) foreach (rsv_f[i]) rsv[op == rfdl_pkg::OP_SET_WLOCK][i] |= rsv_f[i];
  endtask : lock_write

  // lock array read: 32 data words, lock bytes then the reserved bytes set so far, all checked
  task automatic read_lock(input logic [7:0] op, input logic [63:0] exp);
    int i;
    fr = {op};
    for (i = 0; i < rfdl_pkg::ARR_BYTES; i++)
      ans_q.push_back(i < 8 ? {2'b10, exp[8*i+:8]} : {2'b10, rsv[op == rfdl_pkg::OP_RD_WLOCK][i-8]});
    rdr.send_frame(fr, 1'b1);
    wait_answers();
  endtask : read_lock

  task automatic pwd(input logic [31:0] p, input logic [3:0] n);
    fr = {rfdl_pkg::OP_PWD, p[31:24], p[23:16], p[15:8], p[7:0]};
    expect_nib(n);
    rdr.send_frame(fr, 1'b1);
    wait_answers();
  endtask : pwd

  // page write; a serial request during the memory cycle must wait
  task automatic page_write(input logic [7:0] pg, input logic ok);
    int k;
    logic [7:0] d;
    fr = {rfdl_pkg::OP_PAGE_WRITE, pg};
    for (k = 0; k < 64; k++) begin
      d = 8'($random(seed));
      fr.push_back(d);
      if (ok) mem_q.push_back({pg[5:0], 6'(k), d});
    end
    expect_nib(ok ? rfdl_pkg::ACK_CODE : rfdl_pkg::NAK_CODE);
    rdr.send_frame(fr, 1'b1);
    if (ok) begin
      repeat (10) @(posedge core_clk);
      #1 ser_cmd = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 ser_cmd = 1'b0;
    end
    wait_answers();
    check(64'(mem_q.size()), 64'h0);
  endtask : page_write

  // watchdog
  initial begin
    #500000;
    failures++;
    close_out();
  end

  // main sequence
  initial begin
    seed = 32'ha61a52c3;
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    rf_idle = 1'b0;
    ser_cmd = 1'b0;
    mem_busy = 1'b0;
    lock_password = $random(seed);
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    check(page_writelock_array | page_readlock_array, 64'h0);
    check(64'(datamem_unlocked_state), 64'h0);
    read_lock(rfdl_pkg::OP_RD_WLOCK, 64'h0);
    page_write(8'($random(seed)) & 8'h3F, 1'b1);
    wl_exp = {$random(seed), $random(seed)} | 64'h8;
    lock_write(rfdl_pkg::OP_SET_WLOCK, wl_exp, rfdl_pkg::NAK_CODE);
    check(page_writelock_array, 64'h0);
    pwd(lock_password ^ 32'h1, rfdl_pkg::NAK_CODE);
    check(64'(datamem_unlocked_state), 64'h0);
    pwd(lock_password, rfdl_pkg::ACK_CODE);
    check(64'(datamem_unlocked_state), 64'h1);
    lock_write(rfdl_pkg::OP_SET_WLOCK, wl_exp, rfdl_pkg::ACK_CODE);
    check(page_writelock_array, wl_exp);
    tmp = {$random(seed), $random(seed)};
    lock_write(rfdl_pkg::OP_SET_WLOCK, tmp, rfdl_pkg::ACK_CODE);
    wl_exp = wl_exp | tmp;
    check(page_writelock_array, wl_exp);
    rl_exp = {$random(seed), $random(seed)};
    lock_write(rfdl_pkg::OP_SET_RLOCK, rl_exp, rfdl_pkg::ACK_CODE);
    check(page_readlock_array, rl_exp);
    lock_write(8'hA5, 64'h0, rfdl_pkg::NAK_CODE);
    read_lock(rfdl_pkg::OP_RD_RLOCK, rl_exp);
    read_lock(rfdl_pkg::OP_RD_WLOCK, wl_exp);
    page_write(8'h03, 1'b0);
    page_write(8'h40, 1'b0);
    lock_frame(rfdl_pkg::OP_SET_RLOCK, ~rl_exp);
    expect_nib(rfdl_pkg::NAK_CODE);
    rdr.send_frame(fr, 1'b0);
    wait_answers();
    check(page_readlock_array, rl_exp);
    fr = {rfdl_pkg::OP_PWD, 8'h00, 8'h00, 8'h00, 8'h00};
    fork
      rdr.send_frame(fr, 1'b1);
      begin
        repeat (20) @(posedge core_clk);
        #1 ser_cmd = 1'b1;
      end
    join
    repeat (10) @(posedge core_clk);
    #1 ser_cmd = 1'b0;
    repeat (300) @(posedge core_clk);
    #1;
    check(64'(datamem_unlocked_state), 64'h1);
    rf_idle = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rf_idle = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(64'(datamem_unlocked_state), 64'h0);
    lock_write(rfdl_pkg::OP_SET_RLOCK, ~64'h0, rfdl_pkg::NAK_CODE);
    check(page_readlock_array, rl_exp);
    close_out();
  end
endmodule : tb_top
